// File: design/sfcd_spi_frame.sv
// SPI frame checksum, register decode and register storage
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1 - Bits 24 to 31 of every frame, both directions, hold the checksum when protection is on.
// RL2 - CRC-8, polynomial 0x2F, start 0xFF, no reflection, final XOR 0xFF.
// RL3 - Engine yields check value 0xDF and residue 0x42.
// RL4 - Checksum covers only frame bits 0 to 23, both directions.
// RL5 - Outbound bits 8 to 23 return stored content of addressed register.
// RL6 - Bad inbound checksum with protection on sets checksum-error flag.
// RL7 - Protection off: inbound filler must be 0xA5, else error flag set.
// RL8 - Protection off: outbound bits 24 to 31 always 0x5A.
// RL9 - Reading the checksum status register skips the check, sets no flag.
// RL10 - Read-only status bit shows whether protection is active.
// RL11 - Host formats status clear frames per current checksum setting.
// RL12 - Control registers: bit 7 low reads, bit 7 high also writes; the code ignores writes to 0x3D.
// RL13 - Control decode 0x01-0x0B, 0x10-0x1D, 0x30-0x3F.
// RL14 - Status decode 0x40-0x46, 0x50-0x5B, 0x60-0x63, family at 0x70.
// RL15 - Written value appears only in responses of later frames.
// RL16 - Status register: bit 7 high clears payload, low only reads.
// RL17 - Live or fixed value registers ignore clear requests.
// RL18 - Mode change updates mode bits to the mode reached.
// RL19 - Low-power entry keeps diagnosis; Stop keeps transceiver bits.
// RL20 - Sleep entry forces transceiver bits unless off or wake-capable.
// RL21 - Banked registers: payload bits 8-10 pick bank, rest sets it; the code ignores bit 11 and stores bits 12-23.
// RL22 - Banked read: zero bit, three bank bits, then bank content.
// RL23 - Host is advised to clear wake and failure bits after reading.
// RL24 - Bits 6-0 address, bit 7 access type, bits 23-8 payload.
// RL25 - Status field bit 7 is SPI failure OR checksum error.
// RL26 - Written configuration takes effect after chip select rises.
// RL27 - CRC over three bytes from address byte on, each MSB first.
module sfcd_spi_frame (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // SPI pins
  input  wire logic        chip_select_low,
  input  wire logic        sclk,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // Checksum strap pin
  input  wire logic        crc_enable,
  output logic             crc_active,
  // Device status sources
  input  wire logic        stat_set_valid,
  input  wire logic [6:0]  stat_set_addr,
  input  wire logic [15:0] stat_set_bits,
  input  wire logic        spi_fail_set,
  input  wire logic [15:0] wake_pin_level_reg,
  input  wire logic [15:0] wake_osc_calibration_reg,
  input  wire logic [15:0] wake_error_counter_reg,
  input  wire logic [15:0] wake_clock_recovery_reg,
  // Mode transitions
  input  wire logic        mode_update,
  input  wire logic [1:0]  mode_reached,
  // Committed configuration
  output logic             cfg_update,
  output logic [6:0]       cfg_addr,
  output logic [15:0]      cfg_data
);

  sfcd_pkg::sfcd_state_t q;
  sfcd_pkg::sfcd_state_t next_q;

  function automatic logic [7:0] crc24(input logic [23:0] d);
    logic [7:0] c;
    logic       fb;
    int         i;
    c = sfcd_pkg::CRC_INIT; // [RL2]
    for (i = 0; i < 24; i++) begin
      // Address byte first, each byte msb first
      fb = c[7] ^ d[8 * (i / 8) + 7 - (i % 8)]; // [RL27] [RL4]
      c = {c[6:0], 1'b0} ^ (fb ? sfcd_pkg::CRC_POLY : 8'h00); // [RL2]
    end
    return c ^ sfcd_pkg::CRC_XOR; // [RL2] [RL3]
  endfunction

  function automatic logic in_rng(input logic [6:0] a, input logic [6:0] lo,
                                  input logic [6:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic ctrl_valid(input logic [6:0] a);
    return in_rng(a, sfcd_pkg::DEV_CTRL_LO, sfcd_pkg::DEV_CTRL_HI) ||
           in_rng(a, sfcd_pkg::BRG_CTRL_LO, sfcd_pkg::BRG_CTRL_HI) ||
           in_rng(a, sfcd_pkg::SWK_CTRL_LO, sfcd_pkg::SWK_CTRL_HI); // [RL13]
  endfunction

  function automatic logic stat_valid(input logic [6:0] a);
    return in_rng(a, sfcd_pkg::DEV_STAT_LO, sfcd_pkg::DEV_STAT_HI) ||
           in_rng(a, sfcd_pkg::BRG_STAT_LO, sfcd_pkg::BRG_STAT_HI) ||
           in_rng(a, sfcd_pkg::SWK_STAT_LO, sfcd_pkg::SWK_STAT_HI); // [RL14]
  endfunction

  // Live and fixed registers hold no stored bits to clear
  function automatic logic stat_clearable(input logic [6:0] a);
    return stat_valid(a) && (a != sfcd_pkg::WAKE_LVL_ADDR) &&
           (a != sfcd_pkg::ECNT_ADDR) && (a != sfcd_pkg::CDR_ADDR); // [RL17]
  endfunction

  // Bit 3 is the hit flag, bits 2:0 the banked register number
  function automatic logic [3:0] bank_of(input logic [6:0] a);
    logic [3:0] r;
    int         i;
    r = 4'h0;
    for (i = 0; i < sfcd_pkg::NUM_BANKED; i++) begin
      if (sfcd_pkg::BANK_ADDRS[i] == a) begin
        r = {1'b1, i[2:0]};
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] read_reg(input sfcd_pkg::sfcd_state_t s,
                                           input logic [6:0] a);
    logic [15:0] r;
    r = 16'h0000;
    if (a == sfcd_pkg::OSC_CAL_ADDR) begin
      r = wake_osc_calibration_reg;
    end else if (ctrl_valid(a)) begin
      r = s.ctrl[a[5:0]]; // [RL5]
    end else if (a == sfcd_pkg::WAKE_LVL_ADDR) begin
      r = wake_pin_level_reg;
    end else if (a == sfcd_pkg::ECNT_ADDR) begin
      r = wake_error_counter_reg;
    end else if (a == sfcd_pkg::CDR_ADDR) begin
      r = wake_clock_recovery_reg;
    end else if (a == sfcd_pkg::FAMILY_ADDR) begin
      r = sfcd_pkg::PRODUCT_FAMILY_ID; // [RL14]
    end else if (stat_valid(a)) begin
      r = s.stat[a[5:0]];
      if (a == sfcd_pkg::DEV_STAT_ADDR) begin
        r[sfcd_pkg::CRC_STAT_BIT] = s.en2; // [RL10]
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] info_field(input sfcd_pkg::sfcd_state_t s);
    logic [7:0]  f;
    logic [15:0] dev;
    int          i;
    f = 8'h00;
    for (i = 0; i < 5; i++) begin
      f[i] = |s.stat[i];
    end
    dev = s.stat[sfcd_pkg::DEV_STAT_ADDR[5:0]];
    dev[sfcd_pkg::CRC_FAIL_BIT] = 1'b0;
    dev[sfcd_pkg::CRC_STAT_BIT] = 1'b0;
    f[5] = |dev;
    f[6] = |s.stat[sfcd_pkg::INFO_ADDR6[5:0]];
    f[7] = s.stat[sfcd_pkg::DEV_STAT_ADDR[5:0]][sfcd_pkg::SPI_FAIL_BIT] |
           s.stat[sfcd_pkg::DEV_STAT_ADDR[5:0]][sfcd_pkg::CRC_FAIL_BIT];
    return f; // [RL25]
  endfunction

  logic        cs_fall;
  logic        cs_rise;
  logic        ck_rise;
  logic        ck_fall;
  logic [6:0]  c_addr;
  logic        c_wr;
  logic [15:0] c_pay;
  logic [3:0]  c_bank;
  logic        c_ok;
  logic [3:0]  rd_bank;
  logic [7:0]  info;

  // Synchronisers store active-high select so the reset state is idle
  assign cs_fall = q.cs2 & ~q.cs3;
  assign cs_rise = ~q.cs2 & q.cs3;
  assign ck_rise = q.ck2 & ~q.ck3;
  assign ck_fall = ~q.ck2 & q.ck3;
  assign c_addr  = q.rx[6:0]; // [RL24]
  assign c_wr    = q.rx[7]; // [RL24]
  assign c_pay   = q.rx[23:8]; // [RL24]
  assign c_bank  = bank_of(c_addr);
  assign rd_bank = bank_of(q.rx[6:0]);
  assign info    = info_field(q); // [RL25]

  // Read of the checksum status register is exempt from the check
  assign c_ok = (!c_wr && c_addr == sfcd_pkg::DEV_STAT_ADDR) || // [RL9]
                (q.en2 ? q.rx[31:24] == crc24(q.rx[23:0]) // [RL6] [RL1]
                       : q.rx[31:24] == sfcd_pkg::FILL_IN); // [RL7]

  always_comb begin
    next_q = q;
    next_q.cs1 = ~chip_select_low;
    next_q.cs2 = q.cs1;
    next_q.cs3 = q.cs2;
    next_q.ck1 = sclk;
    next_q.ck2 = q.ck1;
    next_q.ck3 = q.ck2;
    next_q.di1 = sdi;
    next_q.di2 = q.di1;
    next_q.en1 = crc_enable;
    next_q.en2 = q.en1;
    next_q.cfg_update = 1'b0;

    if (cs_fall) begin
      next_q.cnt = 6'h00;
      next_q.banked = 1'b0;
      next_q.tx = {24'h000000, info};
      next_q.sdo = info[0];
      next_q.sdo_oe = 1'b1;
    end else if (q.cs2 && ck_rise && q.cnt < sfcd_pkg::FRAME_BITS) begin
      next_q.rx[q.cnt[4:0]] = q.di2;
      next_q.cnt = q.cnt + 6'h01;
      // Address complete: fetch the old content, not a pending write
      if (q.cnt == sfcd_pkg::ADDR_LAST) begin
        next_q.tx[23:8] = read_reg(q, q.rx[6:0]); // [RL5] [RL15]
        next_q.banked = rd_bank[3];
        if (rd_bank[3]) begin
          next_q.tx[8] = 1'b0; // [RL22]
        end
      end
      // Bank number is only known three bits into the payload
      if (q.cnt == sfcd_pkg::BANK_LAST && q.banked) begin
        next_q.tx[23:12] = q.bank[rd_bank[2:0]][{q.di2, q.rx[9:8]}]; // [RL22]
        next_q.tx[11:9] = {q.di2, q.rx[9:8]}; // [RL22]
      end
      if (q.cnt == sfcd_pkg::PAYLD_LAST) begin
        next_q.tx[31:24] = q.en2 ? crc24(q.tx[23:0]) // [RL1] [RL4]
                                 : sfcd_pkg::FILL_OUT; // [RL8]
      end
    end

    if (q.cs2 && ck_fall && q.cnt < sfcd_pkg::FRAME_BITS) begin
      if (q.banked && q.cnt >= sfcd_pkg::BANK_OUT_LO &&
          q.cnt <= sfcd_pkg::BANK_OUT_HI) begin
        next_q.sdo = q.rx[q.cnt[4:0] - 5'h01]; // [RL22]
      end else begin
        next_q.sdo = q.tx[q.cnt[4:0]];
      end
    end

    if (cs_rise) begin
      next_q.sdo = 1'b0;
      next_q.sdo_oe = 1'b0;
      // Only a complete frame is acted on, at chip select release
      if (q.cnt == sfcd_pkg::FRAME_BITS) begin
        if (!c_ok) begin
          next_q.stat[sfcd_pkg::DEV_STAT_ADDR[5:0]]
                     [sfcd_pkg::CRC_FAIL_BIT] = 1'b1; // [RL6] [RL7]
        end else if (c_wr) begin
          if (ctrl_valid(c_addr) && c_addr != sfcd_pkg::OSC_CAL_ADDR) begin
            if (c_bank[3]) begin
              next_q.bank[c_bank[2:0]][c_pay[2:0]] = c_pay[15:4]; // [RL21]
            end else begin
              next_q.ctrl[c_addr[5:0]] = c_pay; // [RL12] [RL26]
            end
            next_q.cfg_update = 1'b1; // [RL26]
            next_q.cfg_addr = c_addr;
            next_q.cfg_data = c_pay;
          end else if (stat_clearable(c_addr)) begin
            next_q.stat[c_addr[5:0]] = 16'h0000; // [RL16] [RL17]
          end
        end
      end
    end

    // Diagnosis is never cleared here; only mode and transceiver bits
    if (mode_update) begin
      next_q.ctrl[sfcd_pkg::MODE_ADDR[5:0]][1:0] = mode_reached; // [RL18]
      if (mode_reached == sfcd_pkg::MODE_SLEEP &&
          q.ctrl[sfcd_pkg::BUS_ADDR[5:0]][2:0] != sfcd_pkg::BUS_OFF &&
          q.ctrl[sfcd_pkg::BUS_ADDR[5:0]][2:0] != sfcd_pkg::BUS_WAKE) begin
        next_q.ctrl[sfcd_pkg::BUS_ADDR[5:0]][2:0] =
          sfcd_pkg::BUS_WAKE; // [RL20]
      end
      // Stop entry leaves transceiver bits as they are [RL19]
    end

    // Hardware sets come last so they win over a clear in the same cycle
    if (stat_set_valid && stat_clearable(stat_set_addr)) begin
      next_q.stat[stat_set_addr[5:0]] = next_q.stat[stat_set_addr[5:0]] |
                                        stat_set_bits;
    end
    if (spi_fail_set) begin
      next_q.stat[sfcd_pkg::DEV_STAT_ADDR[5:0]]
                 [sfcd_pkg::SPI_FAIL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sdo        = q.sdo;
  assign sdo_oe     = q.sdo_oe;
  assign crc_active = q.en2;
  assign cfg_update = q.cfg_update;
  assign cfg_addr   = q.cfg_addr;
  assign cfg_data   = q.cfg_data;

endmodule

`default_nettype wire

// File: pkg/sfcd_pkg.sv
// Constants and state type of the SPI frame check and register decode block
package sfcd_pkg;
  // Frame layout
  localparam logic [5:0] FRAME_BITS  = 6'h20;
  localparam logic [5:0] ADDR_LAST   = 6'h07;
  localparam logic [5:0] BANK_LAST   = 6'h0a;
  localparam logic [5:0] PAYLD_LAST  = 6'h17;
  localparam logic [5:0] BANK_OUT_LO = 6'h09;
  localparam logic [5:0] BANK_OUT_HI = 6'h0a;
  localparam logic [5:0] BANK_ZERO   = 6'h08;

  // Checksum engine
  localparam logic [7:0] CRC_POLY    = 8'h2f;
  localparam logic [7:0] CRC_INIT    = 8'hff;
  localparam logic [7:0] CRC_XOR     = 8'hff;
  localparam logic [7:0] CRC_CHECK   = 8'hdf;
  localparam logic [7:0] CRC_MAGIC   = 8'h42;
  localparam logic [7:0] FILL_IN     = 8'ha5;
  localparam logic [7:0] FILL_OUT    = 8'h5a;

  // Address ranges
  localparam logic [6:0] DEV_CTRL_LO = 7'h01;
  localparam logic [6:0] DEV_CTRL_HI = 7'h0b;
  localparam logic [6:0] BRG_CTRL_LO = 7'h10;
  localparam logic [6:0] BRG_CTRL_HI = 7'h1d;
  localparam logic [6:0] SWK_CTRL_LO = 7'h30;
  localparam logic [6:0] SWK_CTRL_HI = 7'h3f;
  localparam logic [6:0] DEV_STAT_LO = 7'h40;
  localparam logic [6:0] DEV_STAT_HI = 7'h46;
  localparam logic [6:0] BRG_STAT_LO = 7'h50;
  localparam logic [6:0] BRG_STAT_HI = 7'h5b;
  localparam logic [6:0] SWK_STAT_LO = 7'h60;
  localparam logic [6:0] SWK_STAT_HI = 7'h63;

  // Individual registers
  localparam logic [6:0] MODE_ADDR     = 7'h01;
  localparam logic [6:0] BUS_ADDR      = 7'h04;
  localparam logic [6:0] OSC_CAL_ADDR  = 7'h3d;
  localparam logic [6:0] DEV_STAT_ADDR = 7'h45;
  localparam logic [6:0] WAKE_LVL_ADDR = 7'h46;
  localparam logic [6:0] ECNT_ADDR     = 7'h62;
  localparam logic [6:0] CDR_ADDR      = 7'h63;
  localparam logic [6:0] FAMILY_ADDR   = 7'h70;
  // Arbitrary neutral identification value
  localparam logic [15:0] PRODUCT_FAMILY_ID = 16'h0001;

  // Banked control registers, banked register number is the list position
  localparam logic [7:0][6:0] BANK_ADDRS = {7'h1c, 7'h1b, 7'h1a, 7'h18,
                                            7'h16, 7'h14, 7'h0a, 7'h05};
  localparam int NUM_BANKED = 8;

  // Fields
  localparam int SPI_FAIL_BIT = 2;
  localparam int CRC_FAIL_BIT = 3;
  localparam int CRC_STAT_BIT = 4;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [2:0] BUS_OFF     = 3'h0;
  localparam logic [2:0] BUS_WAKE    = 3'h1;
  localparam logic [6:0] INFO_ADDR6  = 7'h50;

  typedef struct packed {
    logic                   cs1, cs2, cs3;
    logic                   ck1, ck2, ck3;
    logic                   di1, di2;
    logic                   en1, en2;
    logic [5:0]             cnt;
    logic [31:0]            rx;
    logic [31:0]            tx;
    logic                   banked;
    logic                   sdo;
    logic                   sdo_oe;
    logic                   cfg_update;
    logic [6:0]             cfg_addr;
    logic [15:0]            cfg_data;
    logic [63:0][15:0]      ctrl;
    logic [7:0][7:0][11:0]  bank;
    logic [35:0][15:0]      stat;
  } sfcd_state_t;
endpackage

// File: tb/sfcd_monitor.sv
// Port checker for the SPI frame check and register decode block
`timescale 1ns/1ps
`default_nettype none
module sfcd_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // SPI pins
  input wire logic        chip_select_low,
  input wire logic        sclk,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  // Strap and committed configuration
  input wire logic        crc_enable,
  input wire logic        crc_active,
  input wire logic        cfg_update,
  input wire logic [6:0]  cfg_addr,
  input wire logic [15:0] cfg_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_sel_fall; $fell(chip_select_low); endsequence
  sequence s_idle; chip_select_low [*6]; endsequence
  property p_oe_on; s_sel_fall |-> ##[2:5] sdo_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo_oe late");
  property p_oe_off; s_idle |-> !sdo_oe && !sdo; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo driven idle");
  // Sync delay keeps sdo moves inside the low half of sclk
  property p_sdo_move; $changed(sdo) && !chip_select_low |-> !sclk; endproperty
  a_sdo_move: assert property (p_sdo_move) else $error("sdo moved");
  property p_cfg_one; cfg_update |=> !cfg_update; endproperty
  a_cfg_one: assert property (p_cfg_one) else $error("long pulse");
  property p_cfg_late;
    cfg_update |-> chip_select_low && !$past(chip_select_low, 8);
  endproperty
  a_cfg_late: assert property (p_cfg_late) else $error("early cfg");
  property p_cfg_hold;
    $changed(cfg_addr) || $changed(cfg_data) |-> cfg_update;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
  property p_crc_on; crc_enable [*4] |-> crc_active; endproperty
  a_crc_on: assert property (p_crc_on) else $error("crc_active low");
  property p_crc_off; !crc_enable [*4] |-> !crc_active; endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc stuck on");
endmodule
`default_nettype wire

// File: tb/sfcd_host.sv
// Host model: SPI master sending and receiving 32-bit frames
`timescale 1ns/1ps
`default_nettype none
module sfcd_host (
  // SPI pins
  output logic      chip_select_low,
  output logic      sclk,
  output logic      sdi,
  input  wire logic miso,
  // Checksum setting shared with the device strap
  input  wire logic crc_on
);
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] b);
    logic fb;
    for (int j = 7; j >= 0; j--) begin
      fb = c[7] ^ b[j];
      c = {c[6:0], 1'b0} ^ (fb ? sfcd_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  function automatic logic [7:0] crc8(input logic [23:0] v);
    logic [7:0] c;
    c = crc_step(sfcd_pkg::CRC_INIT, v[7:0]);
    c = crc_step(c, v[15:8]);
    c = crc_step(c, v[23:16]);
    return c ^ sfcd_pkg::CRC_XOR;
  endfunction
  task automatic xfer(input logic [6:0] a, input logic w,
                      input logic [15:0] d, input logic bad,
                      output logic [31:0] r);
    logic [31:0] f;
    f[23:0] = {d, w, a};
    // Bad flips one checksum bit on purpose
    f[31:24] = (crc_on ? crc8(f[23:0]) : sfcd_pkg::FILL_IN) ^
               {7'h0, bad};
    chip_select_low = 1'b0;
    sdi = f[0];
    #400;
    for (int k = 0; k < 32; k++) begin
      sclk = 1'b1;
      r[k] = miso;
      #200;
      sclk = 1'b0;
      if (k < 31) sdi = f[k + 1];
      #200;
    end
    chip_select_low = 1'b1;
    // Released line must not look like held data
    sdi = ~sdi;
    #600;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the SPI frame check and register decode block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [6:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] exp;
  } sfcd_row_t;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             crc_enable = 1'b1;
  logic             stat_set_valid = 1'b0;
  logic [6:0]       stat_set_addr = 7'h50;
  logic             spi_fail_set = 1'b0;
  logic [15:0]      wake_pin_level_reg = 16'h0005;
  logic             mode_update = 1'b0;
  logic [1:0]       mode_reached = 2'h0;
  wire logic        chip_select_low, sclk, sdi, sdo, sdo_oe, miso;
  wire logic        crc_active, cfg_update;
  wire logic [6:0]  cfg_addr;
  wire logic [15:0] cfg_data;
  logic [31:0]      r;
  logic [7:0]       c;
  int               errors = 0;
  int               checked = 0;
  int               cycles = 0;
  sfcd_row_t        rows [16] = '{
    '{7'h10, 1'b1, 16'h1234, 16'h0000}, '{7'h10, 1'b0, 16'hffff, 16'h1234},
    '{7'h0b, 1'b1, 16'habcd, 16'h0000}, '{7'h3f, 1'b1, 16'h5555, 16'h0000},
    '{7'h0c, 1'b1, 16'h7777, 16'h0000}, '{7'h0b, 1'b0, 16'h0000, 16'habcd},
    '{7'h3f, 1'b0, 16'h0000, 16'h5555}, '{7'h0c, 1'b0, 16'h0000, 16'h0000},
    '{7'h10, 1'b0, 16'h0000, 16'h1234},
    '{7'h70, 1'b1, 16'hffff, sfcd_pkg::PRODUCT_FAMILY_ID},
    '{7'h3d, 1'b1, 16'h0000, 16'h0c0c}, '{7'h62, 1'b1, 16'h0000, 16'h0e0e},
    '{7'h63, 1'b1, 16'h0000, 16'h0d0d}, '{7'h05, 1'b1, 16'habc3, 16'h0006},
    '{7'h05, 1'b0, 16'h0003, 16'habc6}, '{7'h05, 1'b0, 16'h0002, 16'h0004}};

  sfcd_spi_frame DUT (
    .clk, .sys_rst, .chip_select_low, .sclk, .sdi, .sdo, .sdo_oe,
    .crc_enable, .crc_active, .stat_set_valid, .stat_set_addr,
    .stat_set_bits(16'h0003), .spi_fail_set, .wake_pin_level_reg,
    .wake_osc_calibration_reg(16'h0c0c), .wake_error_counter_reg(16'h0e0e),
    .wake_clock_recovery_reg(16'h0d0d), .mode_update, .mode_reached,
    .cfg_update, .cfg_addr, .cfg_data);
  sfcd_host u_host (.chip_select_low, .sclk, .sdi, .miso, .crc_on(crc_enable));
  assign miso = sdo_oe ? sdo : 1'bz;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic frame(input logic [6:0] a, input logic w,
                       input logic [15:0] d, input logic bad);
    logic [7:0] f;
    u_host.xfer(a, w, d, bad, r);
    f = crc_enable ? u_host.crc8(r[23:0]) : sfcd_pkg::FILL_OUT;
    chk(16'(r[31:24]), 16'(f));
  endtask
  task automatic mode(input logic [1:0] m);
    mode_reached = m;
    mode_update = 1'b1;
    tick(1);
    mode_update = 1'b0;
  endtask

  initial begin
    tick(6);
    chk({sdo, sdo_oe, cfg_update, cfg_addr, 6'h00}, 16'h0000);
    sys_rst = 1'b0;
    tick(4);
    chk(16'(crc_active), 16'h0001);
    c = 8'hff;
    for (int i = 1; i < 10; i++) c = u_host.crc_step(c, 8'(8'h30 + i));
    chk(16'(c ^ 8'hff), 16'(sfcd_pkg::CRC_CHECK));
    chk(16'(u_host.crc_step(c, c ^ 8'hff)), 16'(sfcd_pkg::CRC_MAGIC));
    chk(16'(u_host.crc8(24'h8301f2)), 16'h00c2);
    foreach (rows[i]) begin
      frame(rows[i].a, rows[i].w, rows[i].d, 1'b0);
      chk(r[23:8], rows[i].exp);
    end
    // Corrupted checksum: frame dropped and flagged
    frame(7'h11, 1'b1, 16'hdead, 1'b1);
    frame(7'h11, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0000);
    chk(16'(r[7]), 16'h0001);
    frame(7'h45, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0018);
    frame(7'h45, 1'b1, 16'h0000, 1'b0);
    frame(7'h45, 1'b0, 16'h0000, 1'b1);
    frame(7'h45, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0010);
    frame(7'h46, 1'b1, 16'h0000, 1'b0);
    frame(7'h46, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0005);
    stat_set_valid = 1'b1;
    spi_fail_set = 1'b1;
    tick(1);
    stat_set_valid = 1'b0;
    spi_fail_set = 1'b0;
    frame(7'h50, 1'b0, 16'h0000, 1'b0);
    chk({r[23:8]}, 16'h0003);
    chk(16'(r[7:6]), 16'h0003);
    frame(7'h50, 1'b1, 16'h0000, 1'b0);
    frame(7'h45, 1'b1, 16'h0000, 1'b0);
    frame(7'h50, 1'b0, 16'h0000, 1'b0);
    chk({r[23:8]}, 16'h0000);
    chk(16'(r[7]), 16'h0000);
    // Checksum off: filler in both directions
    crc_enable = 1'b0;
    tick(4);
    chk(16'(crc_active), 16'h0000);
    frame(7'h12, 1'b1, 16'h4242, 1'b1);
    frame(7'h12, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0000);
    chk(16'(r[7]), 16'h0001);
    frame(7'h45, 1'b0, 16'h0000, 1'b1);
    chk(r[23:8], 16'h0008);
    frame(7'h04, 1'b1, 16'h0003, 1'b0);
    chk(16'(cfg_addr), 16'h0004);
    chk(cfg_data, 16'h0003);
    mode(sfcd_pkg::MODE_STOP);
    frame(7'h04, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0003);
    frame(7'h01, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0002);
    mode(sfcd_pkg::MODE_SLEEP);
    frame(7'h04, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0001);
    frame(7'h01, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0001);
    // Set aimed at a control address must not alias into status storage
    stat_set_addr = 7'h12;
    stat_set_valid = 1'b1;
    tick(1);
    stat_set_valid = 1'b0;
    frame(7'h52, 1'b0, 16'h0000, 1'b0);
    chk(r[23:8], 16'h0000);
    end_sim();
  end
endmodule
bind sfcd_spi_frame sfcd_monitor u_mon (.clk, .sys_rst, .chip_select_low,
  .sclk, .sdo, .sdo_oe, .crc_enable, .crc_active, .cfg_update, .cfg_addr,
  .cfg_data);
`default_nettype wire
